/* logic/ccd_frame_readout_sequencer.sv */
// Host-side timing generator that reads one full frame out of a two-phase CCD
// ****************************************************************************
// Function
// - Host keeps light off during readout
// - Wide range: gate B blocks, A follows H2
// - High gain: gate A blocks, B follows H2
// - Reset pulse before each pixel's reference sample
// - Both vertical phases low while integrating
// - Row transfer starts with V1 high alone
// - Then V1 low and V2 high together
// - Swap back, then V1 low ends transfer
// - Row fully transferred before shifting out
// - Horizontal phases driven complementary during horizontal shifting
// - Repeat until every row is read
// - Wait about 32 us before horizontal shifting
// ****************************************************************************
`timescale 1ns/1ps
`default_nettype none
module ccd_frame_readout_sequencer
    import ccd_seq_pkg::*;
#(
    parameter int VH_WAIT = VH_CYCLES,
    parameter int FIFO_DEPTH = 8
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic start_i,
    input wire logic high_gain_sel_i,
    output logic busy_o,
    output logic light_inhibit_o,
    output logic vertical_phase_one_o,
    output logic vertical_phase_two_o,
    output logic horizontal_phase_one_o,
    output logic horizontal_phase_two_o,
    output logic split_last_gate_a_o,
    output logic split_last_gate_b_o,
    output logic reset_clock_o,
    output logic sample_strobe_o,
    output logic [TAG_W-1:0] tag_data_o,
    output logic tag_valid_o,
    input wire logic tag_ready_i
);
    seq_state_t state, next_state;
    ccd_clocks_t clks, next_clks;
    logic [CNT_W-1:0] row, next_row, col, next_col;
    logic [TMR_W-1:0] tmr, next_tmr;
    logic gain, next_gain;
    logic strobe, next_strobe, is_sig, next_is_sig;
    logic busy, next_busy;
    logic fifo_ready, fifo_out_valid;
    logic [TAG_W-1:0] fifo_out_data;
    sample_tag_t tag;
    logic tmr_done;

    // ************************************************************************
    // Sequencer
    // ************************************************************************
    assign tmr_done = (tmr == TMR_RESET);

    always_comb begin
        next_state = state;
        next_clks = clks;
        next_row = row;
        next_col = col;
        next_tmr = tmr_done ? tmr : tmr - 1'b1;
        next_gain = gain;
        next_strobe = 1'b0;
        next_is_sig = is_sig;
        case (state)
            ST_IDLE: begin
                // Integration: both vertical phases parked low
                next_clks = '0;
                if (start_i) begin
                    next_gain = high_gain_sel_i;
                    next_row = CNT_RESET;
                    next_clks.vertical_phase_one = 1'b1;
                    next_tmr = TMR_W'(V_STEP_CYCLES - 1);
                    next_state = ST_V_MERGE;
                end
            end
            ST_V_MERGE: if (tmr_done) begin
                // V2 rising here moves the nearest row into the serial register
                next_clks.vertical_phase_one = 1'b0;
                next_clks.vertical_phase_two = 1'b1;
                next_tmr = TMR_W'(V_STEP_CYCLES - 1);
                next_state = ST_V_SWAP1;
            end
            ST_V_SWAP1: if (tmr_done) begin
                next_clks.vertical_phase_one = 1'b1;
                next_clks.vertical_phase_two = 1'b0;
                next_tmr = TMR_W'(V_STEP_CYCLES - 1);
                next_state = ST_V_SWAP2;
            end
            ST_V_SWAP2: if (tmr_done) begin
                next_clks.vertical_phase_one = 1'b0;
                next_tmr = TMR_W'(VH_WAIT - 1);
                next_state = ST_VH_WAIT;
            end
            ST_VH_WAIT: if (tmr_done) begin
                // Horizontal shifting only once the row sits in the register
                next_col = CNT_RESET;
                next_clks.reset_clock = 1'b1;
                // Park H2 high so the first pixel of a row also gets a falling edge
                next_clks.horizontal_phase_one = 1'b0;
                next_clks.horizontal_phase_two = 1'b1;
                next_tmr = TMR_W'(RST_CYCLES - 1);
                next_state = ST_H_RESET;
            end
            ST_H_RESET: if (tmr_done) begin
                next_clks.reset_clock = 1'b0;
                next_tmr = TMR_W'(H_HALF_CYCLES - 1);
                next_state = ST_H_REF;
            end
            ST_H_REF: if (tmr_done && fifo_ready) begin
                // Reference level sampled after reset; H2 falls to dump packet
                next_strobe = 1'b1;
                next_is_sig = 1'b0;
                next_clks.horizontal_phase_one = 1'b1;
                next_clks.horizontal_phase_two = 1'b0;
                next_tmr = TMR_W'(H_HALF_CYCLES - 1);
                next_state = ST_H_XFER;
            end
            ST_H_XFER: if (tmr_done && fifo_ready) begin
                next_strobe = 1'b1;
                next_is_sig = 1'b1;
                next_state = ST_H_SIG;
            end
            ST_H_SIG: begin
                // Horizontal lines hold through the vertical transfer; they move only inside a row
                if (col == CNT_W'(ROW_PIXELS - 1)) begin
                    if (row == CNT_W'(FRAME_ROWS - 1)) begin
                        next_state = ST_IDLE;
                    end else begin
                        next_row = row + 1'b1;
                        next_clks.vertical_phase_one = 1'b1;
                        next_tmr = TMR_W'(V_STEP_CYCLES - 1);
                        next_state = ST_V_MERGE;
                    end
                end else begin
                    next_col = col + 1'b1;
                    next_clks.horizontal_phase_one = 1'b0;
                    next_clks.horizontal_phase_two = 1'b1;
                    next_clks.reset_clock = 1'b1;
                    next_tmr = TMR_W'(RST_CYCLES - 1);
                    next_state = ST_H_RESET;
                end
            end
            default: next_state = ST_IDLE;
        endcase
        // Split gate routing; the blocked gate stays low
        next_clks.split_last_gate_a = next_gain ? 1'b0 : next_clks.horizontal_phase_two;
        next_clks.split_last_gate_b = next_gain ? next_clks.horizontal_phase_two : 1'b0;
        next_busy = (next_state != ST_IDLE);
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= ST_IDLE;
            clks <= '0;
            row <= CNT_RESET;
            col <= CNT_RESET;
            tmr <= TMR_RESET;
            gain <= 1'b0;
            strobe <= 1'b0;
            is_sig <= 1'b0;
            busy <= 1'b0;
        end else begin
            state <= next_state;
            clks <= next_clks;
            row <= next_row;
            col <= next_col;
            tmr <= next_tmr;
            gain <= next_gain;
            strobe <= next_strobe;
            is_sig <= next_is_sig;
            busy <= next_busy;
        end
    end

    // ************************************************************************
    // Sample tag FIFO
    // ************************************************************************
    // Tags ride with strobes; a stalled drain stretches the pixel period
    always_comb begin
        tag.row = row;
        tag.col = col;
        tag.dark_row = dark_row_f(row);
        tag.dark_col = dark_col_f(col);
        tag.is_signal = is_sig;
        tag.last_in_frame = (row == CNT_W'(FRAME_ROWS - 1)) && (col == CNT_W'(ROW_PIXELS - 1));
    end

    tag_fifo #(.WIDTH(TAG_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .in_data_i(tag),
        .in_valid_i(strobe),
        .in_ready_o(fifo_ready),
        .out_data_o(fifo_out_data),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(tag_ready_i)
    );

    assign tag_data_o = fifo_out_data;
    assign tag_valid_o = fifo_out_valid;
    assign sample_strobe_o = strobe;
    assign busy_o = busy;
    assign light_inhibit_o = busy;
    assign vertical_phase_one_o = clks.vertical_phase_one;
    assign vertical_phase_two_o = clks.vertical_phase_two;
    assign horizontal_phase_one_o = clks.horizontal_phase_one;
    assign horizontal_phase_two_o = clks.horizontal_phase_two;
    assign split_last_gate_a_o = clks.split_last_gate_a;
    assign split_last_gate_b_o = clks.split_last_gate_b;
    assign reset_clock_o = clks.reset_clock;

    // ************************************************************************
    // Assertions
    // ************************************************************************
    a_vert_idle_low: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (state == ST_IDLE) |-> (!clks.vertical_phase_one && !clks.vertical_phase_two))
        else $error("vertical phase high while integrating");
    a_merge_first: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(clks.vertical_phase_one) && $past(state) != ST_V_SWAP1 |-> !clks.vertical_phase_two)
        else $error("merge step with phase two high");
    a_swap_together: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(clks.vertical_phase_two) |-> $fell(clks.vertical_phase_one))
        else $error("vertical phases did not swap together");
    a_second_swap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(clks.vertical_phase_two) |-> ##8 (clks.vertical_phase_one && !clks.vertical_phase_two) ##8
        !clks.vertical_phase_one)
        else $error("second vertical swap or end missing");
    a_h_complement: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (state inside {ST_H_RESET, ST_H_REF, ST_H_XFER, ST_H_SIG}) |->
        (clks.horizontal_phase_one != clks.horizontal_phase_two))
        else $error("horizontal phases not complementary");
    a_split_gate: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (!gain |-> (!clks.split_last_gate_b && clks.split_last_gate_a == clks.horizontal_phase_two)) and
        (gain |-> (!clks.split_last_gate_a && clks.split_last_gate_b == clks.horizontal_phase_two)))
        else $error("split gate routing wrong");
    a_reset_pulse: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(clks.reset_clock) |-> clks.reset_clock [*2] ##1 !clks.reset_clock)
        else $error("reset pulse width wrong");
    a_vert_static_h: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (state inside {ST_V_MERGE, ST_V_SWAP1, ST_V_SWAP2, ST_VH_WAIT}) |->
        ($stable(clks.horizontal_phase_two) && !clks.reset_clock))
        else $error("horizontal moved during vertical transfer");
    a_strobe_after_reset: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $fell(clks.reset_clock) |-> ##[10:1000] strobe)
        else $error("no sample strobe after reset");
endmodule : ccd_frame_readout_sequencer
`default_nettype wire

/* logic/ccd_seq_pkg.sv */
// Package: constants, types and timing for the frame readout sequencer
package ccd_seq_pkg;
    // Array geometry
    localparam int IMG_COLS = 1024;
    localparam int IMG_ROWS = 1024;
    localparam int LEAD_DARK_COLS = 4;
    localparam int TRAIL_DARK_COLS = 8;
    localparam int TOP_DARK_ROWS = 4;
    localparam int BOTTOM_DARK_ROWS = 4;
    localparam int ROW_PIXELS = LEAD_DARK_COLS + IMG_COLS + TRAIL_DARK_COLS;
    localparam int FRAME_ROWS = TOP_DARK_ROWS + IMG_ROWS + BOTTOM_DARK_ROWS;
    localparam int CNT_W = 11;

    // Timing
    localparam int CLK_HZ = 40_000_000;
    localparam int VH_TIME_US = 32;
    localparam int VH_CYCLES = (VH_TIME_US * (CLK_HZ / 1_000_000));
    localparam int V_STEP_CYCLES = 8;
    localparam int H_HALF_CYCLES = 10;
    localparam int RST_CYCLES = 2;
    localparam int TMR_W = 16;

    // Reset values
    localparam logic [CNT_W-1:0] CNT_RESET = 11'h000;
    localparam logic [TMR_W-1:0] TMR_RESET = 16'h0000;

    // Sequencer states
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_V_MERGE = 4'h1,
        ST_V_SWAP1 = 4'h2,
        ST_V_SWAP2 = 4'h3,
        ST_V_END = 4'h4,
        ST_VH_WAIT = 4'h5,
        ST_H_RESET = 4'h6,
        ST_H_REF = 4'h7,
        ST_H_XFER = 4'h8,
        ST_H_SIG = 4'h9
    } seq_state_t;

    // Clock lines driven to the sensor
    typedef struct packed {
        logic vertical_phase_one;
        logic vertical_phase_two;
        logic horizontal_phase_one;
        logic horizontal_phase_two;
        logic split_last_gate_a;
        logic split_last_gate_b;
        logic reset_clock;
    } ccd_clocks_t;

    // Sample record: tags and sample kind
    typedef struct packed {
        logic [CNT_W-1:0] row;
        logic [CNT_W-1:0] col;
        logic dark_row;
        logic dark_col;
        logic is_signal;
        logic last_in_frame;
    } sample_tag_t;

    localparam int TAG_W = $bits(sample_tag_t);

    function automatic logic dark_col_f(input logic [CNT_W-1:0] c);
        dark_col_f = (c < CNT_W'(LEAD_DARK_COLS)) || (c >= CNT_W'(LEAD_DARK_COLS + IMG_COLS));
    endfunction : dark_col_f

    function automatic logic dark_row_f(input logic [CNT_W-1:0] r);
        dark_row_f = (r < CNT_W'(TOP_DARK_ROWS)) || (r >= CNT_W'(TOP_DARK_ROWS + IMG_ROWS));
    endfunction : dark_row_f
endpackage : ccd_seq_pkg

/* logic/tag_fifo.sv */
// Synchronous valid/ready FIFO held in flip-flops
`timescale 1ns/1ps
`default_nettype none
module tag_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [WIDTH-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    output logic [WIDTH-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [AW:0] count, next_count;
    logic push, pop;
    logic has_data, next_has_data;

    always_comb begin
        push = in_valid_i && (count != (AW+1)'(DEPTH));
        pop = out_ready_i && (count != '0);
        next_wr_ptr = push ? ((wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1) : wr_ptr;
        next_rd_ptr = pop ? ((rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1) : rd_ptr;
        next_count = count + (AW+1)'(push) - (AW+1)'(pop);
        // Registered so the valid output leaves a flip-flop directly
        next_has_data = (next_count != '0);
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            has_data <= 1'b0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
            has_data <= next_has_data;
        end
    end

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    assign in_ready_o = (count != (AW+1)'(DEPTH));
    assign out_valid_o = has_data;
    assign out_data_o = mem[rd_ptr];
endmodule : tag_fifo
`default_nettype wire

/* verif/ccd_sensor_model.sv */
// Behavioural full-frame sensor that checks the clock lines it receives
`timescale 1ns/1ps
`default_nettype none
module ccd_sensor_model
    import ccd_seq_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic high_gain_sel_i,
    input wire logic light_off_i,
    input wire ccd_clocks_t c_i,
    output int rows_o,
    output int faults_o
);
    ccd_clocks_t p;
    logic rst_seen;
    logic gate_ok;
    int pix;
    initial begin
        rows_o = 0;
        faults_o = 0;
    end
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            p = '0;
            rst_seen = 1'b0;
            pix = 0;
            rows_o = 0;
        end else begin
            // No storage area, so any vertical motion needs the light off
            if ((c_i.vertical_phase_one || c_i.vertical_phase_two) && !light_off_i) faults_o++;
            if (c_i.vertical_phase_one && !p.vertical_phase_one && c_i.vertical_phase_two) faults_o++;
            if (c_i.vertical_phase_two != p.vertical_phase_two && c_i.vertical_phase_one == p.vertical_phase_one)
                faults_o++;
            if (c_i.vertical_phase_two && !p.vertical_phase_two) begin
                rows_o++;
                pix = 0;
            end
            if (rows_o > FRAME_ROWS) faults_o++;
            if ((p.vertical_phase_one || p.vertical_phase_two) && c_i[4:0] != p[4:0]) faults_o++;
            if (c_i.horizontal_phase_one && c_i.horizontal_phase_two) faults_o++;
            gate_ok = high_gain_sel_i ?
                (!c_i.split_last_gate_a && c_i.split_last_gate_b == c_i.horizontal_phase_two) :
                (!c_i.split_last_gate_b && c_i.split_last_gate_a == c_i.horizontal_phase_two);
            if (!gate_ok) faults_o++;
            if (c_i.reset_clock) rst_seen = 1'b1;
            if (p.horizontal_phase_two && !c_i.horizontal_phase_two) begin
                if (!rst_seen || rows_o == 0) faults_o++;
                rst_seen = 1'b0;
                pix++;
                if (pix > ROW_PIXELS) faults_o++;
            end
            p = c_i;
        end
    end
endmodule : ccd_sensor_model
`default_nettype wire

/* verif/ccd_frame_readout_sequencer_tb.sv */
// Self-checking bench for the frame readout sequencer
`timescale 1ns/1ps
`default_nettype none
module ccd_frame_readout_sequencer_tb;
    import ccd_seq_pkg::*;
    // Short wait keeps two partial frames well inside the cycle budget
    localparam int VHW = 4;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic start_i = 1'b0;
    logic high_gain_sel_i = 1'b0;
    logic tag_ready_i = 1'b0;
    logic busy_o, light_inhibit_o, v1, v2, h1, h2, ga, gb, rc, strobe, tag_valid_o, pv1, pv2, exp_sig, gain;
    logic [TAG_W-1:0] tag_data_o;
    logic [31:0] lfsr = 32'ha2d4b84f;
    ccd_clocks_t lines;
    sample_tag_t tag;
    int err_total = 0;
    int compares = 0;
    int faults, rows, t_v1, t_v2, t_v2f, t_rc, n_strobe, exp_row, exp_col;
    int cyc = 0;
    always #12.5 clk_i = ~clk_i;
    assign lines = {v1, v2, h1, h2, ga, gb, rc};

    ccd_frame_readout_sequencer #(.VH_WAIT(VHW), .FIFO_DEPTH(8)) u_ccd_frame_readout_sequencer (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .start_i(start_i), .high_gain_sel_i(high_gain_sel_i),
        .busy_o(busy_o), .light_inhibit_o(light_inhibit_o), .vertical_phase_one_o(v1),
        .vertical_phase_two_o(v2), .horizontal_phase_one_o(h1), .horizontal_phase_two_o(h2),
        .split_last_gate_a_o(ga), .split_last_gate_b_o(gb), .reset_clock_o(rc), .sample_strobe_o(strobe),
        .tag_data_o(tag_data_o), .tag_valid_o(tag_valid_o), .tag_ready_i(tag_ready_i));
    ccd_sensor_model u_ccd_sensor_model (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .high_gain_sel_i(high_gain_sel_i), .light_off_i(light_inhibit_o),
        .c_i(lines), .rows_o(rows), .faults_o(faults));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        lfsr_next = {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h00000000);
    endfunction : lfsr_next

    function automatic logic dark_edge(input int n, input int lead, input int last);
        dark_edge = (n < lead) || (n > last);
    endfunction : dark_edge

    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (exp !== got) begin
            err_total++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, got);
        end
    endtask : cmp

    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : stop_test

    // ****************************************************************
    // Monitor: edge stamps, strobe count and tag checks
    // ****************************************************************
    always @(posedge clk_i) begin
        cyc++;
        if (v1 && !pv1 && t_v1 < 0) t_v1 = cyc;
        // First row of the frame only, so later rows do not overwrite the stamps
        if (v2 && !pv2 && t_v2 < 0) t_v2 = cyc;
        if (!v2 && pv2 && t_v2f < 0) t_v2f = cyc;
        if (rc && t_rc < 0) t_rc = cyc;
        pv1 = v1;
        pv2 = v2;
        if (strobe) n_strobe++;
        cmp("light inhibit", busy_o, light_inhibit_o);
        if (!busy_o) cmp("vertical idle", 0, {v1, v2});
        if (tag_valid_o && tag_ready_i && rst_n_i) begin
            tag = tag_data_o;
            cmp("tag row", exp_row, tag.row);
            cmp("tag col", exp_col, tag.col);
            cmp("tag dark row", dark_edge(exp_row, 4, 1027), tag.dark_row);
            cmp("tag dark col", dark_edge(exp_col, 4, 1027), tag.dark_col);
            cmp("tag kind", exp_sig, tag.is_signal);
            cmp("tag last", exp_row == 1031 && exp_col == 1035, tag.last_in_frame);
            exp_sig = !exp_sig;
            if (!exp_sig) begin
                exp_col++;
                if (exp_col == 1036) begin
                    exp_col = 0;
                    exp_row++;
                end
            end
        end
    end

    // Full FIFO first, then random stalls; a second start is sent mid-frame at cycle 5000, only when span exceeds 5000
    task automatic run_frame(input logic g, input int span, input int exp_rows);
        exp_row = 0;
        exp_col = 0;
        exp_sig = 1'b0;
        t_v1 = -1;
        t_v2 = -1;
        t_v2f = -1;
        t_rc = -1;
        n_strobe = 0;
        high_gain_sel_i <= g;
        start_i <= 1'b1;
        @(posedge clk_i);
        start_i <= 1'b0;
        for (int i = 0; i < span; i++) begin
            @(posedge clk_i);
            lfsr = lfsr_next(lfsr);
            tag_ready_i <= (i >= 600) && (lfsr[1:0] != 2'b00);
            start_i <= (i == 5000);
            if (i == 0) cmp("busy after start", 1, busy_o);
            if (i == 600) cmp("strobes while full", 8, n_strobe);
            if (i == 600) cmp("tag valid while full", 1, tag_valid_o);
        end
        cmp("merge length", 8, t_v2 - t_v1);
        cmp("phase two high", 8, t_v2f - t_v2);
        cmp("row to shift wait", 24 + VHW, t_rc - t_v1);
        cmp("rows loaded", exp_rows, rows);
        cmp("rows read out", exp_rows - 1, exp_row);
        cmp("sensor faults", 0, faults);
    endtask : run_frame

    initial begin
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1'b1;
        gain = lfsr[0];
        run_frame(gain, 26000, 2);
        rst_n_i <= 1'b0;
        @(posedge clk_i);
        #1;
        cmp("outputs in reset", 0, {busy_o, v1, v2, h1, h2, ga, gb, rc, strobe, tag_valid_o});
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        run_frame(!gain, 2000, 1);
        stop_test();
    end
endmodule : ccd_frame_readout_sequencer_tb
`default_nettype wire
